// >>> common/advert_policy_pkg.sv
// Constants and types shared by the source current advertisement policy
package advert_policy_pkg;

  // ==========================================================================
  // Current levels, in units of 100 mA
  localparam int unsigned CUR_W         = 6;
  localparam logic [5:0]  CUR_1A5       = 6'h0f;
  localparam logic [5:0]  CUR_3A0       = 6'h1e;
  localparam logic [5:0]  CUR_5A0       = 6'h32;

  // ==========================================================================
  // Pull-up termination codes
  localparam logic [1:0]  TERM_DEFAULT  = 2'h0;
  localparam logic [1:0]  TERM_1A5      = 2'h1;
  localparam logic [1:0]  TERM_3A0      = 2'h2;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_FREQ_HZ   = 25000000;
  localparam int unsigned VBUS_STABLE_US = 100;
  localparam int unsigned VBUS_STABLE_CYC =
    (VBUS_STABLE_US * (CLK_FREQ_HZ / 1000000));

  // ==========================================================================
  // Port connection states
  typedef enum logic [4:0] {
    ST_DETACHED = 5'b00001,
    ST_POWERING = 5'b00010,
    ST_READY    = 5'b00100,
    ST_CONTRACT = 5'b01000,
    ST_DISCOVER = 5'b10000
  } port_state_t;

endpackage

// >>> verilog/stable_timer.sv
// Counts a settling delay after start and holds done until cleared
`timescale 1ns/1ps

module stable_timer #(
  parameter int unsigned COUNT = 2500
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Control
  input  wire logic run,
  output logic      done
);

  localparam int unsigned CW = $clog2(COUNT + 1);
  logic [CW-1:0] count;

  initial begin
    if (COUNT < 1) $error("stable_timer COUNT must be at least 1");
  end

  // ==========================================================================
  // Counter restarts whenever run drops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      done  <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count <= '0;
        done  <= 1'b0;
      end else if (count == CW'(COUNT - 1)) begin
        done <= 1'b1;
      end else begin
        count <= count + CW'(1);
      end
    end
  end

endmodule

// >>> verilog/source_current_advert_policy.sv
// Source port policy: current advertisement, VBUS gating, PD gating
`timescale 1ns/1ps

module source_current_advert_policy
  import advert_policy_pkg::*;
#(
  parameter int unsigned STABLE_CYC = VBUS_STABLE_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // Static configuration
  input  wire logic [CUR_W-1:0]  supply_capability,
  input  wire logic              captive_cable,
  input  wire logic              pd_supported,
  input  wire logic              high_voltage_capable,
  input  wire logic              role_swap_capable,
  input  wire logic              always_on_vbus,
  input  wire logic [CUR_W-1:0]  captive_cable_limit,
  // Channel comparator pins (asynchronous)
  input  wire logic              sink_attached_pin,
  input  wire logic              channel_open_level_pin,
  input  wire logic              vbus_good_pin,
  // PD controller events
  input  wire logic              contract_active,
  input  wire logic              first_ps_rdy_goodcrc,
  input  wire logic              identity_done,
  input  wire logic [CUR_W-1:0]  identity_cable_limit,
  // Proprietary method request
  input  wire logic              prop_request,
  input  wire logic [CUR_W-1:0]  prop_current,
  input  wire logic              prop_voltage_change,
  input  wire logic              prop_role_change,
  // Outputs to analog front end and PD controller
  output logic [1:0]             source_pullup_termination,
  output logic                   vbus_enable,
  output logic                   pd_tx_allowed,
  output logic                   pd_biphase_enable,
  output logic                   discover_identity_req,
  output logic                   legacy_negotiation_allowed,
  output logic [CUR_W-1:0]       advertised_limit,
  output logic                   prop_accept
);

  port_state_t   state;
  port_state_t   next_state;
  logic [1:0]    attach_sync;
  logic [1:0]    open_sync;
  logic [1:0]    vbus_sync;
  logic          attached;
  logic          vbus_stable;
  logic          cable_known;
  logic [CUR_W-1:0] cable_limit;
  logic [CUR_W-1:0] next_limit;
  logic [1:0]    next_term;
  logic          pd_only;

  initial begin
    if (STABLE_CYC < 1) $error("STABLE_CYC must be at least 1");
  end

  // Highest termination a current limit can support
  function automatic logic [1:0] term_for(input logic [CUR_W-1:0] cur);
    if (cur >= CUR_3A0) begin
      term_for = TERM_3A0;
    end else if (cur >= CUR_1A5) begin
      term_for = TERM_1A5;
    end else begin
      term_for = TERM_DEFAULT;
    end
  endfunction

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      attach_sync <= 2'h0;
      open_sync   <= 2'h3;
      vbus_sync   <= 2'h0;
    end else if (clk_en) begin
      attach_sync <= {attach_sync[0], sink_attached_pin};
      open_sync   <= {open_sync[0], channel_open_level_pin};
      vbus_sync   <= {vbus_sync[0], vbus_good_pin};
    end
  end

  // Open level on the channel overrides a stale attach indication
  assign attached = attach_sync[1] & ~open_sync[1];

  // ==========================================================================
  // VBUS settling timer
  stable_timer #(
    .COUNT (STABLE_CYC)
  ) u_stable (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .run     (vbus_enable & vbus_sync[1]),
    .done    (vbus_stable)
  );

  // ==========================================================================
  // Connection state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_DETACHED: begin
        if (attached) begin
          next_state = ST_POWERING;
        end
      end
      ST_POWERING: begin
        if (!attached) begin
          next_state = ST_DETACHED;
        end else if (vbus_stable) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (!attached) begin
          next_state = ST_DETACHED;
        end else if (supply_capability > CUR_3A0 && pd_supported && !cable_known) begin
          next_state = ST_DISCOVER;
        end else if (contract_active && first_ps_rdy_goodcrc) begin
          next_state = ST_CONTRACT;
        end
      end
      ST_DISCOVER: begin
        if (!attached) begin
          next_state = ST_DETACHED;
        end else if (identity_done) begin
          next_state = ST_READY;
        end
      end
      ST_CONTRACT: begin
        if (!attached) begin
          next_state = ST_DETACHED;
        end else if (!contract_active) begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_DETACHED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_DETACHED;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Cable capability learned from Discover Identity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cable_known <= 1'b0;
      cable_limit <= '0;
    end else if (clk_en) begin
      if (state == ST_DETACHED) begin
        cable_known <= 1'b0;
        cable_limit <= '0;
      end else if (state == ST_DISCOVER && identity_done) begin
        cable_known <= 1'b1;
        cable_limit <= identity_cable_limit;
      end
    end
  end

  // ==========================================================================
  // Advertised current limit
  always_comb begin
    next_limit = supply_capability;
    if (captive_cable) begin
      if (next_limit > captive_cable_limit) begin
        next_limit = captive_cable_limit;
      end
      if (next_limit > CUR_5A0) begin
        next_limit = CUR_5A0;
      end
    end else if (cable_known) begin
      if (next_limit > cable_limit) begin
        next_limit = cable_limit;
      end
    end else if (next_limit > CUR_3A0) begin
      next_limit = CUR_3A0;
    end
  end

  // Termination follows capability; contract forces at least 1.5 A
  always_comb begin
    next_term = term_for(next_limit);
    if (next_state == ST_CONTRACT && next_term == TERM_DEFAULT) begin
      next_term = TERM_1A5;
    end
  end

  // Termination is always driven, so PD or BC never replaces it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      source_pullup_termination <= TERM_DEFAULT;
      advertised_limit          <= '0;
    end else if (clk_en) begin
      source_pullup_termination <= next_term;
      advertised_limit          <= next_limit;
    end
  end

  // ==========================================================================
  // VBUS gating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vbus_enable <= 1'b0;
    end else if (clk_en) begin
      if (captive_cable && !pd_supported && always_on_vbus) begin
        vbus_enable <= 1'b1;
      end else begin
        vbus_enable <= (next_state != ST_DETACHED);
      end
    end
  end

  // ==========================================================================
  // PD messaging permissions
  assign pd_only = high_voltage_capable | role_swap_capable;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_tx_allowed              <= 1'b0;
      pd_biphase_enable          <= 1'b0;
      discover_identity_req      <= 1'b0;
      legacy_negotiation_allowed <= 1'b0;
    end else if (clk_en) begin
      // Held off one cycle on contract entry so the new termination lands first
      pd_tx_allowed <= pd_supported && (state == next_state) &&
                       (state == ST_READY || state == ST_CONTRACT ||
                        state == ST_DISCOVER);
      pd_biphase_enable <= pd_supported;
      discover_identity_req <= (next_state == ST_DISCOVER);
      legacy_negotiation_allowed <= !pd_only && (next_state != ST_DETACHED);
    end
  end

  // ==========================================================================
  // Proprietary charging requests
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prop_accept <= 1'b0;
    end else if (clk_en) begin
      prop_accept <= prop_request && !pd_only &&
                     !prop_voltage_change && !prop_role_change &&
                     (state == ST_READY) &&
                     (prop_current <= CUR_3A0 ||
                      (captive_cable && prop_current <= captive_cable_limit &&
                       prop_current <= CUR_5A0));
    end
  end

endmodule

// >>> tb/sink_partner.sv
// Behavioural sink port with its power delivery controller
`timescale 1ns/1ps

module sink_partner
  import advert_policy_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Bench commands
  input  wire logic             attach,
  input  wire logic             go,
  input  wire logic [CUR_W-1:0] lim,
  // Source side outputs
  input  wire logic             vbus_en,
  input  wire logic             disc_req,
  // Sink side of the channel
  output logic                  attached,
  output logic                  open_level,
  output logic                  vbus_good,
  output logic                  contract,
  output logic                  goodcrc,
  output logic                  id_done,
  output logic [CUR_W-1:0]      id_limit
);
  logic [2:0] ramp;
  logic       answered;

  // =====
  // Attach and detach seen as channel levels
  assign attached   = attach;
  assign open_level = !attach;
  // Slow VBUS rise, so the stable wait really matters
  assign vbus_good  = ramp[2];
  // Limit is only valid with its pulse; elsewhere it shows garbage
  assign id_limit   = id_done ? lim : ~lim;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp     <= 3'h0;
      contract <= 1'b0;
      goodcrc  <= 1'b0;
      id_done  <= 1'b0;
      answered <= 1'b0;
    end else begin
      ramp     <= {ramp[1:0], vbus_en};
      contract <= go && attach;
      goodcrc  <= go && attach;
      id_done  <= disc_req && !answered;
      answered <= attach && (answered || disc_req);
    end
  end
endmodule

// >>> tb/source_current_advert_policy_monitor.sv
// Port checker of the source advertisement policy
`timescale 1ns/1ps

module source_current_advert_policy_monitor
  import advert_policy_pkg::*;
#(
  parameter int unsigned STABLE_CYC = 4
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Configuration and channel
  input wire logic [5:0] supply_capability,
  input wire logic       captive_cable,
  input wire logic [5:0] captive_cable_limit,
  input wire logic       high_voltage_capable,
  input wire logic       role_swap_capable,
  input wire logic       always_on_vbus,
  input wire logic       sink_attached_pin,
  input wire logic       channel_open_level_pin,
  input wire logic       vbus_good_pin,
  input wire logic       contract_active,
  input wire logic       prop_voltage_change,
  // Outputs
  input wire logic [1:0] source_pullup_termination,
  input wire logic       vbus_enable,
  input wire logic       pd_tx_allowed,
  input wire logic       legacy_negotiation_allowed,
  input wire logic [5:0] advertised_limit,
  input wire logic       prop_accept
);
  logic [15:0] good_cnt;

  // =====
  // Cycles of good VBUS while enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) good_cnt <= 16'h0;
    else if (!(vbus_good_pin && vbus_enable)) good_cnt <= 16'h0;
    else if (good_cnt != 16'hffff) good_cnt <= good_cnt + 16'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // =====
  // Properties
  term_high_a: assert property ($past(reset_n) && vbus_enable
    && supply_capability >= CUR_3A0
    && (!captive_cable || captive_cable_limit >= CUR_3A0) |-> source_pullup_termination == TERM_3A0)
    else $error("termination below 3.0 A level");
  // A captive cable rated under 1.5 A rightly keeps the default level
  term_mid_a: assert property ($past(reset_n) && vbus_enable
    && supply_capability >= CUR_1A5
    && (!captive_cable || captive_cable_limit >= CUR_1A5)
    |-> source_pullup_termination != TERM_DEFAULT) else $error("termination left at default");
  term_legal_a: assert property (source_pullup_termination != 2'h3)
    else $error("illegal termination code");
  open_off_a: assert property ((channel_open_level_pin && !always_on_vbus) [*5]
    |-> !vbus_enable) else $error("VBUS kept at open level");
  absent_off_a: assert property ((!sink_attached_pin && !always_on_vbus) [*5]
    |-> !vbus_enable) else $error("VBUS on without sink");
  pd_wait_a: assert property (pd_tx_allowed |-> good_cnt >= STABLE_CYC)
    else $error("PD allowed before VBUS stable");
  contract_term_a: assert property ($fell(pd_tx_allowed) && contract_active
    |-> source_pullup_termination != TERM_DEFAULT) else $error("contract without raised level");
  captive_cap_a: assert property (captive_cable
    |-> advertised_limit <= captive_cable_limit
    && advertised_limit <= CUR_5A0) else $error("advertised above cable");
  prop_safe_a: assert property (prop_accept |-> !$past(prop_voltage_change)
    && !high_voltage_capable && !role_swap_capable) else $error("bad proprietary accept");
  pd_only_a: assert property (legacy_negotiation_allowed
    |-> !high_voltage_capable && !role_swap_capable) else $error("legacy on PD-only source");

  cover property (contract_active && source_pullup_termination != TERM_DEFAULT);
  cover property ($rose(prop_accept));
  cover property ($fell(vbus_enable));
endmodule

bind source_current_advert_policy source_current_advert_policy_monitor #(
  .STABLE_CYC(STABLE_CYC)
) i_mon (
  .clk(clk), .reset_n(reset_n), .supply_capability(supply_capability),
  .captive_cable(captive_cable), .captive_cable_limit(captive_cable_limit),
  .high_voltage_capable(high_voltage_capable), .role_swap_capable(role_swap_capable),
  .always_on_vbus(always_on_vbus), .sink_attached_pin(sink_attached_pin),
  .channel_open_level_pin(channel_open_level_pin), .vbus_good_pin(vbus_good_pin),
  .contract_active(contract_active), .prop_voltage_change(prop_voltage_change),
  .source_pullup_termination(source_pullup_termination), .vbus_enable(vbus_enable),
  .pd_tx_allowed(pd_tx_allowed), .legacy_negotiation_allowed(legacy_negotiation_allowed),
  .advertised_limit(advertised_limit), .prop_accept(prop_accept)
);

// >>> tb/source_current_advert_policy_bench.sv
// Self-checking bench of the source advertisement policy
`timescale 1ns/1ps

module source_current_advert_policy_bench;
  import advert_policy_pkg::*;
  logic             clk, reset_n, attach, go_c, captive, pd, hv, rs, aon;
  logic             preq, pvc, prc, sap, olp, vgp, ca, gc, idd, vbe, pdtx, bmc, disc, leg, pacc;
  logic [CUR_W-1:0] cap, clim, ilim, pcur, icl, adv;
  logic [1:0]       term;
  int               mismatches, comparisons;

  source_current_advert_policy #(.STABLE_CYC(4)) i_dut (
    .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .supply_capability(cap),
    .captive_cable(captive), .pd_supported(pd), .high_voltage_capable(hv),
    .role_swap_capable(rs), .always_on_vbus(aon), .captive_cable_limit(clim),
    .sink_attached_pin(sap), .channel_open_level_pin(olp), .vbus_good_pin(vgp),
    .contract_active(ca), .first_ps_rdy_goodcrc(gc), .identity_done(idd),
    .identity_cable_limit(icl), .prop_request(preq), .prop_current(pcur),
    .prop_voltage_change(pvc), .prop_role_change(prc), .source_pullup_termination(term),
    .vbus_enable(vbe), .pd_tx_allowed(pdtx), .pd_biphase_enable(bmc),
    .discover_identity_req(disc), .legacy_negotiation_allowed(leg),
    .advertised_limit(adv), .prop_accept(pacc)
  );
  sink_partner i_sink (
    .clk(clk), .reset_n(reset_n), .attach(attach), .go(go_c), .lim(ilim),
    .vbus_en(vbe), .disc_req(disc), .attached(sap), .open_level(olp),
    .vbus_good(vgp), .contract(ca), .goodcrc(gc), .id_done(idd), .id_limit(icl)
  );

  // =====
  // Shared tasks
  task conclude();
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [5:0] s, input logic [5:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %0t saw %h expected %h", $time, s, e);
    end
  endtask
  // Bounded wait on discovery or PD permission
  task automatic wt(input logic dsc);
    int n;
    for (n = 0; n < 400; n++) begin
      if ((dsc ? disc : pdtx) === 1'b1) break;
      @(negedge clk);
    end
    if (n == 400) begin
      mismatches++;
      conclude();
    end
  endtask
  // Configuration only changes under reset, as straps would
  task cfg(input logic [5:0] c, input logic cp, p, h, input logic [5:0] l, il);
    @(negedge clk);
    reset_n = 1'b0;
    {attach, go_c, preq, pvc, prc} = 5'h0;
    {cap, captive, pd, hv, clim, ilim} = {c, cp, p, h, l, il};
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
  endtask

  // =====
  // Scenarios
  task s_attach();
    cfg(CUR_3A0, 1'b0, 1'b1, 1'b1, CUR_5A0, CUR_5A0);
    repeat (8) @(negedge clk);
    chk(vbe, 1'b0);
    attach = 1'b1;
    wt(1'b0);
    chk(vbe, 1'b1);
    chk(term, TERM_3A0);
    chk(bmc, 1'b1);
    chk(leg, 1'b0);
  endtask
  task s_contract();
    cfg(6'h0a, 1'b0, 1'b1, 1'b0, CUR_5A0, CUR_5A0);
    attach = 1'b1;
    wt(1'b0);
    chk(term, TERM_DEFAULT);
    go_c = 1'b1;
    repeat (2) @(negedge clk);
    chk(term, TERM_1A5);
    chk(pdtx, 1'b0);
    @(negedge clk);
    chk(term, TERM_1A5);
    chk(pdtx, 1'b1);
    go_c = 1'b0;
    attach = 1'b0;
    repeat (6) @(negedge clk);
    chk(vbe, 1'b0);
    chk(pdtx, 1'b0);
  endtask
  task s_mid();
    cfg(6'h14, 1'b0, 1'b0, 1'b0, CUR_5A0, CUR_5A0);
    attach = 1'b1;
    repeat (20) @(negedge clk);
    chk(vbe, 1'b1);
    chk(term, TERM_1A5);
    chk(leg, 1'b1);
  endtask
  task s_disc();
    cfg(CUR_5A0, 1'b0, 1'b1, 1'b0, CUR_5A0, 6'h28);
    attach = 1'b1;
    wt(1'b1);
    chk(adv, CUR_3A0);
    repeat (4) @(negedge clk);
    chk(adv, 6'h28);
    chk(term, TERM_3A0);
  endtask
  // Table of {current, voltage change, role change, accepted}
  task s_prop();
    logic [8:0] tab [5];
    int         i;
    tab = '{{CUR_3A0, 3'h1}, {6'h28, 3'h1}, {CUR_5A0, 3'h0}, {CUR_3A0, 3'h4}, {CUR_3A0, 3'h2}};
    cfg(CUR_5A0, 1'b1, 1'b0, 1'b0, 6'h28, 6'h28);
    attach = 1'b1;
    repeat (20) @(negedge clk);
    preq = 1'b1;
    for (i = 0; i < 5; i++) begin
      {pcur, pvc, prc} = tab[i][8:1];
      repeat (2) @(negedge clk);
      chk(pacc, tab[i][0]);
    end
  endtask
  // Captive non-PD charger with VBUS always on, role swap capable
  task s_aon();
    @(negedge clk);
    reset_n = 1'b0;
    {rs, aon} = 2'h3;
    cfg(CUR_1A5, 1'b1, 1'b0, 1'b0, CUR_3A0, CUR_3A0);
    repeat (3) @(negedge clk);
    chk(vbe, 1'b1);
    chk(term, TERM_1A5);
    attach = 1'b1;
    preq = 1'b1;
    repeat (20) @(negedge clk);
    chk(leg, 1'b0);
    chk(pacc, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {reset_n, attach, go_c, captive, pd, hv, rs, aon, preq, pvc, prc} = 11'h0;
    {cap, clim, ilim, pcur} = 24'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    s_attach();
    s_contract();
    s_mid();
    s_disc();
    s_prop();
    s_aon();
    conclude();
  end
endmodule
